// [design/seq_regs.svh]
// Reset values, current codes and timing counts of the start-up and latch-off sequencer.
`ifndef SEQ_REGS_SVH
`define SEQ_REGS_SVH
`define CLK_HZ            20000000
`define RESET_MIN_NS      50000
`define RESET_MAX_NS      60000
// Least time rounds up; 50 us at 50 ns is 1000 cycles.
`define RESET_CYCLES      ((`RESET_MIN_NS * 20 + 999) / 1000)
`define BOOT_CODE         7'h30
`define PHASES_RESET      2'h3
// Soft-start current codes in units of 0.5 uA, signed.
`define SS_CHARGE_HALF_UA 8'h10
`define SS_SINK_HALF_UA   8'hFC
`define SS_FAST_CHARGE    8'h7F
`define PG_CHARGE_HALF_UA 8'h04
`define SLEW_2P5          8'h05
`define SLEW_7P5          8'h0F
`define ILIM_MV_PER_UA    8'h0A
`define RAMP_CLAMP_MV     12'h5DC
`endif

// [design/seq_pkg.sv]
// Types shared by the sequencer.
package seq_pkg;
	typedef enum logic [3:0] {
		ST_SHUTDOWN,
		ST_RESET,
		ST_PHASE_DETECT,
		ST_SOFT_START,
		ST_BOOT_HOLD,
		ST_CODE_MOVE,
		ST_GOOD_DELAY,
		ST_NORMAL,
		ST_LATCH_DELAY,
		ST_LATCHED_OFF
	} seq_state_type;
endpackage

// [design/regulator_sequencer.sv]
// Start-up, soft transition and latch-off sequencer of a multiphase regulator controller.
`timescale 1ns/100ps
`include "seq_regs.svh"

// Contract
// R1: Soft-start node held at zero during lockout or shutdown.
// R2: Supply up and enable high: bias on, reset interval of 50 to 60 us.
// R3: After reset, detect phase count, then issue go for soft start.
// R4: Soft start charges the soft-start node at 8 uA.
// R5: Output tracks ramp only up to 1.2 V boot code, then holds.
// R6: At 1.7 V and output in boot window, drive clock permit low.
// R7: After clock permit, read processor code and softly move to it.
// R8: Meanwhile fast-charge soft-start node to 2.9 V clamp.
// R9: Delay node held at zero until clock permit asserted.
// R10: After clock permit, charge delay node at 2 uA.
// R11: Supply-ok rises only at delay node 2.9 V and output in window.
// R12: Enable low or supply under lockout discharges both nodes.
// R13: Reference from converter normally, slew buffer during transitions.
// R14: Slew current by transition: -2.5, +7.5, +2.5, or plus/minus 2.5 uA; the code never drives the one-way +2.5 uA case.
// R15: Limit threshold 10 mV per uA, divided by phases single-phase.
// R16: Below 200 mV at start-up, clamp ramp termination at 1.5 V.
// R17: After overload or good failure sink 2 uA; shut off below 1.65 V.
// R18: Keep switching in latch delay; recover if overload clears and good returns.
// R19: Latched-off stays off until supply cycles or enable toggles.
// R20: Window is -300 mV to +200 mV; under 300 mV only upper checked.
// R21: On current limit force full-phase operation.
// R22: Analog crossings enter as synchronized digital inputs.
// R23: Sequencer is a state machine with the listed states.
module regulator_sequencer
	import seq_pkg::*;
#(
	parameter int RESET_CYCLES = `RESET_CYCLES
) (
	// Clock and reset.
	input  wire logic       MCLK_I,
	input  wire logic       NRST_I,
	// Supply and enable.
	input  wire logic       SUPPLY_ABOVE_UPPER_I,
	input  wire logic       SUPPLY_BELOW_LOWER_I,
	input  wire logic       ENABLE_I,
	// Configuration and processor signals.
	input  wire logic [1:0] PHASE_SELECT_I,
	input  wire logic [6:0] VOLTAGE_ID_CODE_I,
	input  wire logic       DEEP_SLEEP_REQUEST_I,
	input  wire logic       DEEP_STOP_REQUEST_I,
	input  wire logic       CODE_LOW_I,
	// Comparator results.
	input  wire logic       SS_AT_1V7_I,
	input  wire logic       SS_AT_2V9_I,
	input  wire logic       SS_BELOW_1V65_I,
	input  wire logic       DELAY_AT_2V9_I,
	input  wire logic       IN_WINDOW_I,
	input  wire logic       ABOVE_UPPER_LIMIT_I,
	input  wire logic       OUTPUT_BELOW_200MV_I,
	input  wire logic       OVERLOAD_I,
	input  wire logic       TRANSITION_DONE_I,
	// Sequencer outputs.
	output logic            BIAS_ON_O,
	output logic            SWITCHING_O,
	output logic            CPU_CLOCK_PERMIT_N_O,
	output logic            SUPPLY_OK_OUT_O,
	output logic [6:0]      DAC_CODE_O,
	output logic            REF_FROM_SLEW_O,
	output logic [7:0]      SS_CURRENT_O,
	output logic            SS_HOLD_ZERO_O,
	output logic [7:0]      DELAY_CURRENT_O,
	output logic            DELAY_HOLD_ZERO_O,
	output logic [7:0]      SLEW_CURRENT_O,
	output logic            SLEW_BIDIR_O,
	output logic [1:0]      PHASES_O,
	output logic [7:0]      ILIM_SCALE_O,
	output logic            FULL_PHASE_O,
	output logic            RAMP_CLAMP_O,
	output logic [3:0]      STATE_O
);

	initial begin
		if (RESET_CYCLES < 1 || RESET_CYCLES > 65535) begin
			$error("RESET_CYCLES out of range");
		end
	end

	// ------------------------------------------------------------
	// Reset release and input synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 17;
	logic [1:0]       rst_sync_reg;
	logic             rst_n;
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] s1_reg;
	logic [NSYNC-1:0] s2_reg;
	logic [NSYNC-1:0] s3_reg;
	logic [NSYNC-1:0] clean_reg;

	// Reset is released through two flip-flops.
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	assign raw = {SUPPLY_ABOVE_UPPER_I, SUPPLY_BELOW_LOWER_I, ENABLE_I, DEEP_SLEEP_REQUEST_I,
		DEEP_STOP_REQUEST_I, CODE_LOW_I, SS_AT_1V7_I, SS_AT_2V9_I, SS_BELOW_1V65_I,
		DELAY_AT_2V9_I, IN_WINDOW_I, ABOVE_UPPER_LIMIT_I, OUTPUT_BELOW_200MV_I,
		OVERLOAD_I, TRANSITION_DONE_I, PHASE_SELECT_I};

	// Three-stage capture; a change counts once stages two and three agree.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			clean_reg <= '0;
		end else begin
			s1_reg    <= raw;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			for (int i = 0; i < NSYNC; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					clean_reg[i] <= s3_reg[i]; // [R22]
				end
			end
		end
	end

	logic sup_up, sup_low, en, dslp, dstp, code_low, ss17, ss29, ss165, dl29;
	logic in_win, above_up, below200, ovl, tdone;
	logic [1:0] phsel;
	assign {sup_up, sup_low, en, dslp, dstp, code_low, ss17, ss29, ss165, dl29,
		in_win, above_up, below200, ovl, tdone, phsel} = clean_reg;

	// Code capture stages; the code is sampled once settled in the clean domain.
	logic [6:0] code1_reg, code2_reg, code3_reg;
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			code1_reg <= 7'h00;
			code2_reg <= 7'h00;
			code3_reg <= 7'h00;
		end else begin
			code1_reg <= VOLTAGE_ID_CODE_I;
			code2_reg <= code1_reg;
			code3_reg <= code2_reg;
		end
	end

	// Window check: under 300 mV only the upper limit counts.
	function automatic logic window_ok(input logic low, input logic win, input logic up);
		window_ok = low ? !up : win; // [R20]
	endfunction

	// ------------------------------------------------------------
	// Sequencer state machine
	// ------------------------------------------------------------
	seq_state_type state_reg;
	seq_state_type state_next;
	logic [15:0]   cnt_reg;
	logic [1:0]    phases_reg;
	logic [6:0]    code_reg;
	logic          stop;
	logic          good;

	assign stop = !en || sup_low;
	assign good = window_ok(code_low, in_win, above_up);

	// Next state.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_SHUTDOWN:     if (sup_up && en) state_next = ST_RESET; // [R2]
			ST_RESET:        if (cnt_reg == 16'(RESET_CYCLES - 1)) state_next = ST_PHASE_DETECT;
			ST_PHASE_DETECT: state_next = ST_SOFT_START; // [R3]
			ST_SOFT_START:   if (in_win) state_next = ST_BOOT_HOLD;
			ST_BOOT_HOLD:    if (ss17 && in_win) state_next = ST_CODE_MOVE; // [R6]
			ST_CODE_MOVE:    if (tdone) state_next = ST_GOOD_DELAY;
			ST_GOOD_DELAY:   if (dl29 && good) state_next = ST_NORMAL; // [R11]
			ST_NORMAL:       if (ovl || !good) state_next = ST_LATCH_DELAY; // [R17]
			ST_LATCH_DELAY: begin
				if (ss165) state_next = ST_LATCHED_OFF; // [R17]
				else if (!ovl && good) state_next = ST_NORMAL; // [R18]
			end
			ST_LATCHED_OFF:  state_next = ST_LATCHED_OFF; // [R19]
			default:         state_next = ST_SHUTDOWN;
		endcase
		if (stop) begin
			state_next = ST_SHUTDOWN; // [R12] [R19]
		end
	end

	// State register.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_SHUTDOWN;
		end else begin
			state_reg <= state_next; // [R23]
		end
	end

	// Reset interval counter.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
		end else if (state_reg == ST_RESET && state_next == ST_RESET) begin
			cnt_reg <= cnt_reg + 16'h0001; // [R2]
		end else begin
			cnt_reg <= 16'h0000;
		end
	end

	// Phase count is captured in the detection state.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			phases_reg <= `PHASES_RESET;
		end else if (state_reg == ST_PHASE_DETECT) begin
			phases_reg <= (phsel == 2'h0) ? 2'h1 : phsel; // [R3]
		end
	end

	// Converter code: boot code until clock permit, then the processor code.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			code_reg <= `BOOT_CODE;
		end else if (state_reg inside {ST_SHUTDOWN, ST_RESET, ST_PHASE_DETECT,
			ST_SOFT_START, ST_BOOT_HOLD}) begin
			code_reg <= `BOOT_CODE; // [R5]
		end else if (code2_reg == code3_reg) begin
			code_reg <= code3_reg; // [R7]
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	logic       permit_n_reg, ok_reg, bias_reg, sw_reg, ref_reg, ss0_reg, dl0_reg;
	logic       full_reg, clamp_reg, bidir_reg;
	logic [7:0] ss_i_reg, dl_i_reg, sl_i_reg, ilim_reg;
	logic       dslp_d_reg;

	// Clock permit and supply-ok.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			permit_n_reg <= 1'b1;
			ok_reg       <= 1'b0;
		end else begin
			permit_n_reg <= !(state_next inside {ST_CODE_MOVE, ST_GOOD_DELAY, ST_NORMAL,
				ST_LATCH_DELAY}); // [R6]
			ok_reg       <= (state_next == ST_NORMAL); // [R11]
		end
	end

	// Node currents and hold-to-zero controls.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ss0_reg  <= 1'b1;
			dl0_reg  <= 1'b1;
			ss_i_reg <= 8'h00;
			dl_i_reg <= 8'h00;
			bias_reg <= 1'b0;
			sw_reg   <= 1'b0;
		end else begin
			ss0_reg  <= state_next inside {ST_SHUTDOWN, ST_RESET, ST_PHASE_DETECT,
				ST_LATCHED_OFF}; // [R1] [R12]
			dl0_reg  <= permit_n_reg || state_next == ST_SHUTDOWN; // [R9] [R12]
			bias_reg <= state_next != ST_SHUTDOWN; // [R2]
			sw_reg   <= state_next inside {ST_SOFT_START, ST_BOOT_HOLD, ST_CODE_MOVE,
				ST_GOOD_DELAY, ST_NORMAL, ST_LATCH_DELAY}; // [R18]
			case (state_next)
				ST_SOFT_START, ST_BOOT_HOLD: ss_i_reg <= `SS_CHARGE_HALF_UA; // [R4]
				ST_LATCH_DELAY:              ss_i_reg <= `SS_SINK_HALF_UA; // [R17]
				ST_CODE_MOVE, ST_GOOD_DELAY, ST_NORMAL:
					ss_i_reg <= ss29 ? 8'h00 : `SS_FAST_CHARGE; // [R8] [R18]
				default:                     ss_i_reg <= 8'h00;
			endcase
			dl_i_reg <= (state_next inside {ST_GOOD_DELAY, ST_CODE_MOVE} && !dl29)
				? `PG_CHARGE_HALF_UA : 8'h00; // [R10]
		end
	end

	// Reference switch and slew current selection.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ref_reg    <= 1'b0;
			sl_i_reg   <= 8'h00;
			bidir_reg  <= 1'b0;
			dslp_d_reg <= 1'b0;
		end else begin
			dslp_d_reg <= dslp;
			bidir_reg  <= 1'b0;
			if (state_next == ST_CODE_MOVE) begin
				ref_reg   <= 1'b1; // [R13]
				sl_i_reg  <= `SLEW_2P5; // [R14]
				bidir_reg <= 1'b1;
			end else if (state_reg == ST_NORMAL && dslp && !dslp_d_reg) begin
				ref_reg  <= 1'b1;
				sl_i_reg <= -`SLEW_2P5; // [R14]
			end else if (state_reg == ST_NORMAL && !dslp && dslp_d_reg) begin
				ref_reg  <= 1'b1;
				sl_i_reg <= `SLEW_7P5; // [R14]
			end else if (state_reg == ST_NORMAL && dslp && dstp && ref_reg && tdone) begin
				ref_reg  <= 1'b0;
			end else if (tdone || state_next == ST_SHUTDOWN) begin
				ref_reg  <= 1'b0; // [R13]
				sl_i_reg <= 8'h00;
			end
		end
	end

	// Current-limit scaling, full-phase forcing and start-up ramp clamp.
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ilim_reg  <= `ILIM_MV_PER_UA;
			full_reg  <= 1'b0;
			clamp_reg <= 1'b0;
		end else begin
			ilim_reg  <= (dslp && !ovl) ? 8'(`ILIM_MV_PER_UA / phases_reg)
				: `ILIM_MV_PER_UA; // [R15]
			full_reg  <= ovl; // [R21]
			// Follows the next state so the clamp moves with the other start-up outputs.
			clamp_reg <= below200 && state_next inside {ST_SOFT_START, ST_BOOT_HOLD}; // [R16]
		end
	end

	assign BIAS_ON_O            = bias_reg;
	assign SWITCHING_O          = sw_reg;
	assign CPU_CLOCK_PERMIT_N_O = permit_n_reg;
	assign SUPPLY_OK_OUT_O      = ok_reg;
	assign DAC_CODE_O           = code_reg;
	assign REF_FROM_SLEW_O      = ref_reg;
	assign SS_CURRENT_O         = ss_i_reg;
	assign SS_HOLD_ZERO_O       = ss0_reg;
	assign DELAY_CURRENT_O      = dl_i_reg;
	assign DELAY_HOLD_ZERO_O    = dl0_reg;
	assign SLEW_CURRENT_O       = sl_i_reg;
	assign SLEW_BIDIR_O         = bidir_reg;
	assign PHASES_O             = phases_reg;
	assign ILIM_SCALE_O         = ilim_reg;
	assign FULL_PHASE_O         = full_reg;
	assign RAMP_CLAMP_O         = clamp_reg;
	assign STATE_O              = state_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_ss_zero;
		@(posedge MCLK_I) disable iff (!rst_n) (state_reg == ST_SHUTDOWN) |-> ##1 ss0_reg || state_reg != ST_SHUTDOWN;
	endproperty
	a_ss_zero: assert property (p_ss_zero) else $error("soft-start not held"); // [R1]
	property p_reset_len;
		@(posedge MCLK_I) disable iff (!rst_n) $rose(state_reg == ST_PHASE_DETECT) |-> cnt_reg == 0 && $past(state_reg) == ST_RESET;
	endproperty
	a_reset_len: assert property (p_reset_len) else $error("bad reset exit"); // [R2]
	property p_detect;
		@(posedge MCLK_I) disable iff (!rst_n) state_reg == ST_SOFT_START && $past(state_reg) != ST_SOFT_START |-> $past(state_reg) == ST_PHASE_DETECT;
	endproperty
	a_detect: assert property (p_detect) else $error("go before detect"); // [R3]
	property p_permit;
		@(posedge MCLK_I) disable iff (!rst_n) $fell(permit_n_reg) |-> $past(ss17) || $past(state_reg) != ST_BOOT_HOLD;
	endproperty
	a_permit: assert property (p_permit) else $error("permit early"); // [R6]
	property p_delay_zero;
		@(posedge MCLK_I) disable iff (!rst_n) permit_n_reg |-> ##1 dl0_reg;
	endproperty
	a_delay_zero: assert property (p_delay_zero) else $error("delay node not held"); // [R9]
	property p_ok;
		@(posedge MCLK_I) disable iff (!rst_n) $rose(ok_reg) |-> $past(dl29);
	endproperty
	a_ok: assert property (p_ok) else $error("ok without delay"); // [R11]
	property p_stop;
		@(posedge MCLK_I) disable iff (!rst_n) stop |-> ##1 state_reg == ST_SHUTDOWN ##1 ss0_reg;
	endproperty
	a_stop: assert property (p_stop) else $error("no shutdown"); // [R12]
	property p_full;
		@(posedge MCLK_I) disable iff (!rst_n) ovl |-> ##1 full_reg;
	endproperty
	a_full: assert property (p_full) else $error("no full phase"); // [R21]
	c_normal: cover property (@(posedge MCLK_I) disable iff (!rst_n) state_reg == ST_NORMAL);
	c_latch: cover property (@(posedge MCLK_I) disable iff (!rst_n) state_reg == ST_LATCHED_OFF);
	c_recover: cover property (@(posedge MCLK_I) disable iff (!rst_n) state_reg == ST_LATCH_DELAY ##1 state_reg == ST_NORMAL);

endmodule

// [sim/host_cpu_model.sv]
// Host processor model that presents the voltage code and the sleep signals.
`timescale 1ns/100ps
module host_cpu_model #(
	parameter logic [6:0] TARGET_CODE = 7'h1A
) (
	// Clock and sequencer status.
	input  wire logic       clk_i,
	input  wire logic       permit_n_i,
	// Sleep commands from the bench.
	input  wire logic       sleep_cmd_i,
	input  wire logic       stop_cmd_i,
	// Processor outputs.
	output logic [6:0]      code_o,
	output logic            sleep_o,
	output logic            stop_o
);
	// Outputs start defined so the sequencer never samples an unknown.
	initial begin
		code_o = 7'h2A;
		sleep_o = 1'b0;
		stop_o = 1'b0;
	end

	// Before clocks are permitted the code toggles, so an early read is never stable.
	always @(posedge clk_i) begin
		code_o <= permit_n_i ? ~code_o : TARGET_CODE;
		sleep_o <= sleep_cmd_i;
		stop_o <= stop_cmd_i;
	end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the start-up and latch-off sequencer.
`timescale 1ns/100ps
module tb_top;
	import seq_pkg::*;
	localparam int         RST_CYC = 8;
	localparam logic [6:0] HOST    = 7'h1A;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic       MCLK_I = 1'b0;
	logic       NRST_I = 1'b0;
	logic       SUPPLY_ABOVE_UPPER_I = 1'b0;
	logic       SUPPLY_BELOW_LOWER_I = 1'b0;
	logic       ENABLE_I = 1'b0;
	logic [1:0] PHASE_SELECT_I = 2'h2;
	logic       SS_AT_1V7_I = 1'b0;
	logic       SS_AT_2V9_I = 1'b0;
	logic       SS_BELOW_1V65_I = 1'b0;
	logic       DELAY_AT_2V9_I = 1'b0;
	logic       IN_WINDOW_I = 1'b0;
	logic       BELOW_200_I = 1'b0;
	logic       OVERLOAD_I = 1'b0;
	logic       DONE_I = 1'b0;
	logic       CODE_LOW_I = 1'b0;
	logic       ABOVE_UP_I = 1'b0;
	logic       sleep_cmd = 1'b0;
	logic [6:0] code;
	logic       sleep;
	logic       stop;
	logic       BIAS_ON_O;
	logic       SWITCHING_O;
	logic       PERMIT_N_O;
	logic       SUPPLY_OK_O;
	logic [6:0] DAC_CODE_O;
	logic       REF_SLEW_O;
	logic [7:0] SS_CUR_O;
	logic       SS_ZERO_O;
	logic [7:0] DLY_CUR_O;
	logic       DLY_ZERO_O;
	logic [7:0] SLEW_CUR_O;
	logic       SLEW_BIDIR_O;
	logic [1:0] PHASES_O;
	logic [7:0] ILIM_O;
	logic       FULL_PHASE_O;
	logic       CLAMP_O;
	logic [3:0] STATE_O;
	int         n_errors = 0;
	int         n_tests = 0;
	int         cnt;

	// Clock of 50 ns period.
	always #25 MCLK_I = ~MCLK_I;

	regulator_sequencer #(.RESET_CYCLES(RST_CYC)) regulator_sequencer_inst (
		.MCLK_I(MCLK_I), .NRST_I(NRST_I),
		.SUPPLY_ABOVE_UPPER_I(SUPPLY_ABOVE_UPPER_I), .SUPPLY_BELOW_LOWER_I(SUPPLY_BELOW_LOWER_I),
		.ENABLE_I(ENABLE_I), .PHASE_SELECT_I(PHASE_SELECT_I), .VOLTAGE_ID_CODE_I(code),
		.DEEP_SLEEP_REQUEST_I(sleep), .DEEP_STOP_REQUEST_I(stop), .CODE_LOW_I(CODE_LOW_I),
		.SS_AT_1V7_I(SS_AT_1V7_I), .SS_AT_2V9_I(SS_AT_2V9_I), .SS_BELOW_1V65_I(SS_BELOW_1V65_I),
		.DELAY_AT_2V9_I(DELAY_AT_2V9_I), .IN_WINDOW_I(IN_WINDOW_I), .ABOVE_UPPER_LIMIT_I(ABOVE_UP_I),
		.OUTPUT_BELOW_200MV_I(BELOW_200_I), .OVERLOAD_I(OVERLOAD_I), .TRANSITION_DONE_I(DONE_I),
		.BIAS_ON_O(BIAS_ON_O), .SWITCHING_O(SWITCHING_O), .CPU_CLOCK_PERMIT_N_O(PERMIT_N_O),
		.SUPPLY_OK_OUT_O(SUPPLY_OK_O), .DAC_CODE_O(DAC_CODE_O), .REF_FROM_SLEW_O(REF_SLEW_O),
		.SS_CURRENT_O(SS_CUR_O), .SS_HOLD_ZERO_O(SS_ZERO_O), .DELAY_CURRENT_O(DLY_CUR_O),
		.DELAY_HOLD_ZERO_O(DLY_ZERO_O), .SLEW_CURRENT_O(SLEW_CUR_O), .SLEW_BIDIR_O(SLEW_BIDIR_O),
		.PHASES_O(PHASES_O), .ILIM_SCALE_O(ILIM_O), .FULL_PHASE_O(FULL_PHASE_O),
		.RAMP_CLAMP_O(CLAMP_O), .STATE_O(STATE_O)
	);

	host_cpu_model #(.TARGET_CODE(HOST)) host_cpu_model_inst (
		.clk_i(MCLK_I), .permit_n_i(PERMIT_N_O), .sleep_cmd_i(sleep_cmd),
		.stop_cmd_i(1'b0), .code_o(code), .sleep_o(sleep), .stop_o(stop)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Compares with case equality so an unknown never matches.
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Picks the observed value a bounded wait looks at.
	function automatic logic [7:0] probe(input int sel);
		case (sel)
			0: return {4'h0, STATE_O};
			1: return SLEW_CUR_O;
			default: return {7'h00, CLAMP_O};
		endcase
	endfunction

	// Waits a bounded time for a value; running out ends the run.
	task automatic wait_for(input int sel, input logic [7:0] exp);
		int k = 0;
		while (probe(sel) !== exp && k < 3000) begin
			@(negedge MCLK_I);
			k++;
		end
		check(probe(sel), exp, "wait target");
		if (k >= 3000) begin
			give_verdict();
		end
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge MCLK_I);
		NRST_I <= 1'b1;
		repeat (4) @(negedge MCLK_I);
		check(STATE_O, ST_SHUTDOWN, "idle state");
		check(SS_ZERO_O, 1'b1, "ss zero");
		check(DLY_ZERO_O, 1'b1, "delay zero");
		check(BIAS_ON_O, 1'b0, "bias off");
		$display("Test shutdown done");
		@(posedge MCLK_I) SUPPLY_ABOVE_UPPER_I <= 1'b1;
		ENABLE_I <= 1'b1;
		BELOW_200_I <= 1'b1;
		wait_for(0, ST_RESET);
		check(BIAS_ON_O, 1'b1, "bias on");
		cnt = 0;
		while (STATE_O === ST_RESET && cnt < 100) begin
			@(negedge MCLK_I);
			cnt++;
		end
		check(cnt inside {[RST_CYC - 1:RST_CYC + 1]}, 1'b1, "reset length");
		wait_for(0, ST_SOFT_START);
		check(PHASES_O, 2'h2, "phases");
		check(SS_CUR_O, 8'h10, "ss charge");
		check(SS_ZERO_O, 1'b0, "ss released");
		check(CLAMP_O, 1'b1, "ramp clamp");
		@(posedge MCLK_I) BELOW_200_I <= 1'b0;
		wait_for(2, 8'h00);
		@(posedge MCLK_I) IN_WINDOW_I <= 1'b1;
		wait_for(0, ST_BOOT_HOLD);
		check(DAC_CODE_O, 7'h30, "boot code");
		check(PERMIT_N_O, 1'b1, "permit held");
		check(DLY_ZERO_O, 1'b1, "delay zero");
		@(posedge MCLK_I) SS_AT_1V7_I <= 1'b1;
		wait_for(0, ST_CODE_MOVE);
		check(PERMIT_N_O, 1'b0, "permit low");
		check(REF_SLEW_O, 1'b1, "ref slew");
		check(SLEW_CUR_O, 8'h05, "boot slew");
		check(SLEW_BIDIR_O, 1'b1, "slew bidir");
		check(SS_CUR_O, 8'h7F, "fast charge");
		@(posedge MCLK_I) SS_AT_2V9_I <= 1'b1;
		DONE_I <= 1'b1;
		wait_for(0, ST_GOOD_DELAY);
		check(DLY_CUR_O, 8'h04, "delay charge");
		check(REF_SLEW_O, 1'b0, "ref dac");
		check(SUPPLY_OK_O, 1'b0, "ok early");
		check(DAC_CODE_O, HOST, "host code");
		@(posedge MCLK_I) DONE_I <= 1'b0;
		DELAY_AT_2V9_I <= 1'b1;
		wait_for(0, ST_NORMAL);
		check(SUPPLY_OK_O, 1'b1, "ok high");
		$display("Test power up done");
		@(posedge MCLK_I) sleep_cmd <= 1'b1;
		wait_for(1, 8'hFB);
		check(ILIM_O, 8'h05, "ilim single");
		@(posedge MCLK_I) DONE_I <= 1'b1;
		repeat (8) @(posedge MCLK_I);
		DONE_I <= 1'b0;
		sleep_cmd <= 1'b0;
		wait_for(1, 8'h0F);
		check(ILIM_O, 8'h0A, "ilim multi");
		@(posedge MCLK_I) DONE_I <= 1'b1;
		repeat (8) @(posedge MCLK_I);
		DONE_I <= 1'b0;
		$display("Test sleep done");
		// Under 300 mV only the upper limit counts: leaving the window is no failure.
		@(posedge MCLK_I) CODE_LOW_I <= 1'b1;
		IN_WINDOW_I <= 1'b0;
		repeat (10) @(negedge MCLK_I);
		check(STATE_O, ST_NORMAL, "low code window");
		@(posedge MCLK_I) ABOVE_UP_I <= 1'b1;
		wait_for(0, ST_LATCH_DELAY);
		@(posedge MCLK_I) ABOVE_UP_I <= 1'b0;
		CODE_LOW_I <= 1'b0;
		IN_WINDOW_I <= 1'b1;
		wait_for(0, ST_NORMAL);
		$display("Test window done");
		@(posedge MCLK_I) OVERLOAD_I <= 1'b1;
		wait_for(0, ST_LATCH_DELAY);
		check(SS_CUR_O, 8'hFC, "ss sink");
		check(SWITCHING_O, 1'b1, "still switching");
		check(FULL_PHASE_O, 1'b1, "full phase");
		@(posedge MCLK_I) OVERLOAD_I <= 1'b0;
		wait_for(0, ST_NORMAL);
		@(posedge MCLK_I) OVERLOAD_I <= 1'b1;
		wait_for(0, ST_LATCH_DELAY);
		@(posedge MCLK_I) SS_BELOW_1V65_I <= 1'b1;
		wait_for(0, ST_LATCHED_OFF);
		check(SWITCHING_O, 1'b0, "switching off");
		@(posedge MCLK_I) OVERLOAD_I <= 1'b0;
		SS_BELOW_1V65_I <= 1'b0;
		repeat (20) @(negedge MCLK_I);
		check(STATE_O, ST_LATCHED_OFF, "stays off");
		@(posedge MCLK_I) ENABLE_I <= 1'b0;
		wait_for(0, ST_SHUTDOWN);
		check(SS_ZERO_O, 1'b1, "ss zero");
		check(DLY_ZERO_O, 1'b1, "delay zero");
		@(posedge MCLK_I) ENABLE_I <= 1'b1;
		SS_AT_1V7_I <= 1'b0;
		SS_AT_2V9_I <= 1'b0;
		DELAY_AT_2V9_I <= 1'b0;
		wait_for(0, ST_RESET);
		@(posedge MCLK_I) SUPPLY_BELOW_LOWER_I <= 1'b1;
		wait_for(0, ST_SHUTDOWN);
		check(SS_ZERO_O, 1'b1, "ss zero low");
		$display("Test latch off done");
		give_verdict();
	end
endmodule
